// >>> rtl/cfg_regs_pkg.sv
// Purpose: shared constants and carriers for the clock buffer config bytes
// Assumes: byte-wide register port from the serial bus engine
// Notes: offsets are byte indices of one continuous map
package cfg_regs_pkg;
   localparam logic [7:0] OFS_RSVD4 = 8'h04;
   localparam logic [7:0] OFS_REV_MAKER = 8'h05;
   localparam logic [7:0] OFS_DEV_TYPE = 8'h06;
   localparam logic [7:0] OFS_RB_LEN = 8'h07;
   localparam logic [7:0] OFS_RSVD8 = 8'h08;
   localparam logic [7:0] OFS_RSVD9 = 8'h09;
   localparam logic [7:0] OFS_RETAIN = 8'h0A;
   localparam logic [7:0] OFS_STOP_FB = 8'h0B;
   localparam logic [7:0] OFS_IMP_LO = 8'h0C;
   localparam logic [7:0] OFS_IMP_HI = 8'h0D;
   // field positions
   localparam int RETAIN_BIT = 6;
   localparam int FEEDBACK_IMPEDANCE_SELECT_LSB = 6;
   localparam int STOP_LSB = 0;
   localparam int PAIR0_IMP_LSB = 2;
   localparam int PAIR1_IMP_LSB = 6;
   localparam int PAIR2_IMP_LSB = 0;
   localparam int PAIR3_IMP_LSB = 4;
   // reset values and the reserved impedance code
   localparam logic [4:0] RB_LEN_RST = 5'h08;
   localparam logic RETAIN_RST = 1'b1;
   localparam logic [1:0] STOP_RST = 2'h0;
   localparam logic [1:0] IMP_100 = 2'h2;
   localparam logic [1:0] IMP_RSVD = 2'h3;
   // stop-state codes
   localparam logic [1:0] STOP_LOW_LOW = 2'h0;
   localparam logic [1:0] STOP_HIZ = 2'h1;
   localparam logic [1:0] STOP_HIGH_LOW = 2'h2;
   localparam logic [1:0] STOP_LOW_HIGH = 2'h3;

   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic [7:0] rdata;
      logic [4:0] rb_len;
   } reg_rsp_t;
endpackage

// >>> rtl/clock_buffer_config_regs.sv
// Purpose: config bytes 4..13 of a differential clock buffer
// Assumes: serial engine presents one byte access per cycle on req
// Notes: all outputs are registered; pair drive state is a registered decode
`timescale 1ns/1ns
// Notes on behaviour
// [RULE1] byte 5 is read-only: revision code high nibble, maker code low nibble
// [RULE2] byte 6 holds writable 2-bit type and 6-bit identifier
// [RULE3] byte 7 low five bits are read-back length, reset to 8
// [RULE4] block reads return the currently programmed read-back length
// [RULE5] byte 10 bit 6 keeps config on power-down when 1; resets to 1
// [RULE6] stop field: 00 low/low, 01 hiz, 10 high/low, 11 low/high
// [RULE7] each pair and feedback have 2-bit impedance; 11 reserved
// [RULE8] bytes 4, 8, 9 and reserved bits have no effect
// [RULE9] low enable bit forces pair to the programmed stop state
// [RULE10] block read sends length first, then bytes from start index
// [RULE11] writes to read-only and reserved bits are ignored
// [RULE12] host must not write code 11 to an impedance field
module clock_buffer_config_regs #(
   parameter logic [3:0] REVISION_CODE = 4'h0, // arbitrary value
   parameter logic [3:0] MAKER_CODE = 4'h0, // arbitrary value
   parameter logic [1:0] TYPE_RST = 2'h1,
   parameter logic [5:0] PART_ID_RST = 6'h00, // arbitrary value
   parameter logic [1:0] IMP_RST = cfg_regs_pkg::IMP_100
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire cfg_regs_pkg::reg_req_t req,
   input wire logic [3:0] pair_enable,
   input wire logic power_down,
   output cfg_regs_pkg::reg_rsp_t rsp,
   output logic [3:0] pair_true_out,
   output logic [3:0] pair_comp_out,
   output logic [3:0] pair_hiz,
   output logic [9:0] imp_sel,
   output logic config_retain
);
   typedef struct packed {
      logic [7:0] rdata;
      logic [1:0] dev_type;
      logic [5:0] part_id;
      logic [4:0] rb_len;
      logic retain;
      logic [1:0] stop;
      logic [1:0] feedback_impedance_select;
      logic [7:0] pair_imp;
      logic [3:0] t_out;
      logic [3:0] c_out;
      logic [3:0] hiz;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // reads the addressed byte; reserved bits and bytes read as zero
   function automatic logic [7:0] rd_byte(input state_t s,
                                          input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         cfg_regs_pkg::OFS_REV_MAKER: v = {REVISION_CODE, MAKER_CODE}; // RULE1
         cfg_regs_pkg::OFS_DEV_TYPE: v = {s.dev_type, s.part_id}; // RULE2
         cfg_regs_pkg::OFS_RB_LEN: v = {3'h0, s.rb_len}; // RULE3
         cfg_regs_pkg::OFS_RETAIN: v = {1'b0, s.retain, 6'h00}; // RULE5
         cfg_regs_pkg::OFS_STOP_FB: v = {s.feedback_impedance_select, 4'h0, s.stop};
         cfg_regs_pkg::OFS_IMP_LO:
            v = {s.pair_imp[3:2], 2'h0, s.pair_imp[1:0], 2'h0};
         cfg_regs_pkg::OFS_IMP_HI:
            v = {2'h0, s.pair_imp[7:6], 2'h0, s.pair_imp[5:4]};
         default: v = 8'h00; // RULE8
      endcase
      return v;
   endfunction

   // next state: writes, read data and the pair drive decode
   always_comb begin
      st_nxt = st_r;
      if (req.wr) begin
         unique case (req.addr)
            cfg_regs_pkg::OFS_DEV_TYPE: begin
               st_nxt.dev_type = req.wdata[7:6]; // RULE2
               st_nxt.part_id = req.wdata[5:0];
            end
            cfg_regs_pkg::OFS_RB_LEN:
               st_nxt.rb_len = req.wdata[4:0]; // RULE4
            cfg_regs_pkg::OFS_RETAIN:
               st_nxt.retain = req.wdata[cfg_regs_pkg::RETAIN_BIT]; // RULE5
            cfg_regs_pkg::OFS_STOP_FB: begin
               st_nxt.stop = req.wdata[1:0]; // RULE6
               st_nxt.feedback_impedance_select = req.wdata[7:6]; // RULE7
            end
            cfg_regs_pkg::OFS_IMP_LO: begin
               st_nxt.pair_imp[1:0] = req.wdata[3:2]; // RULE7
               st_nxt.pair_imp[3:2] = req.wdata[7:6];
            end
            cfg_regs_pkg::OFS_IMP_HI: begin
               st_nxt.pair_imp[5:4] = req.wdata[1:0];
               st_nxt.pair_imp[7:6] = req.wdata[5:4];
            end
            default: ; // RULE11 read-only, reserved and unmapped bytes
         endcase
      end
      st_nxt.rdata = rd_byte(st_r, req.addr);
      // power-down without retention drops the written configuration
      if (power_down && !st_r.retain) begin // RULE5
         st_nxt.dev_type = TYPE_RST;
         st_nxt.part_id = PART_ID_RST;
         st_nxt.rb_len = cfg_regs_pkg::RB_LEN_RST;
         st_nxt.stop = cfg_regs_pkg::STOP_RST;
         st_nxt.feedback_impedance_select = IMP_RST;
         st_nxt.pair_imp = {4{IMP_RST}};
      end
      // a disabled pair shows the stop state; enabled pairs are left to the
      // analogue driver, so here they only report a static high/low
      for (int i = 0; i < 4; i++) begin
         st_nxt.t_out[i] = 1'b0;
         st_nxt.c_out[i] = 1'b0;
         st_nxt.hiz[i] = 1'b0;
         if (!pair_enable[i]) begin // RULE9
            unique case (st_r.stop) // RULE6
               cfg_regs_pkg::STOP_LOW_LOW: ;
               cfg_regs_pkg::STOP_HIZ: st_nxt.hiz[i] = 1'b1;
               cfg_regs_pkg::STOP_HIGH_LOW: st_nxt.t_out[i] = 1'b1;
               cfg_regs_pkg::STOP_LOW_HIGH: st_nxt.c_out[i] = 1'b1;
            endcase
         end else begin
            st_nxt.t_out[i] = 1'b1;
         end
      end
   end

   // single register stage for all state
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         st_r <= '0;
         st_r.dev_type <= TYPE_RST;
         st_r.part_id <= PART_ID_RST;
         st_r.rb_len <= cfg_regs_pkg::RB_LEN_RST; // RULE3
         st_r.retain <= cfg_regs_pkg::RETAIN_RST; // RULE5
         st_r.stop <= cfg_regs_pkg::STOP_RST; // RULE6
         st_r.feedback_impedance_select <= IMP_RST;
         st_r.pair_imp <= {4{IMP_RST}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // the bus engine sends rb_len as the count byte of a block read
   assign rsp.rdata = st_r.rdata;
   assign rsp.rb_len = st_r.rb_len; // RULE10
   assign pair_true_out = st_r.t_out;
   assign pair_comp_out = st_r.c_out;
   assign pair_hiz = st_r.hiz;
   assign imp_sel = {st_r.feedback_impedance_select, st_r.pair_imp};
   assign config_retain = st_r.retain;

   a_len_reset: assert property (@(posedge mclk) // RULE3
      !resetn |=> rsp.rb_len == cfg_regs_pkg::RB_LEN_RST)
      else $error("read-back length not 8 after reset");
   a_len_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
      req.wr && req.addr == cfg_regs_pkg::OFS_RB_LEN && !power_down
      |=> rsp.rb_len == $past(req.wdata[4:0]))
      else $error("read-back length not updated");
   a_rom_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE1
      req.addr == cfg_regs_pkg::OFS_REV_MAKER
      |=> rsp.rdata == {REVISION_CODE, MAKER_CODE})
      else $error("revision byte wrong");
   a_rsvd_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
      req.addr == cfg_regs_pkg::OFS_RSVD8 |=> rsp.rdata == 8'h00)
      else $error("reserved byte not zero");
   a_type_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE2
      req.wr && req.addr == cfg_regs_pkg::OFS_DEV_TYPE && !power_down
      ##1 req.addr == cfg_regs_pkg::OFS_DEV_TYPE
      |=> rsp.rdata == $past(req.wdata, 2))
      else $error("type byte readback wrong");
   a_stop_hiz: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      !pair_enable[0] && st_r.stop == cfg_regs_pkg::STOP_HIZ
      |=> pair_hiz[0] && !pair_true_out[0])
      else $error("pair not high impedance");
   a_stop_force: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      !pair_enable[1] && st_r.stop == cfg_regs_pkg::STOP_HIGH_LOW
      |=> pair_true_out[1] && !pair_comp_out[1])
      else $error("disabled pair not forced");
   a_retain_pd: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      power_down && !config_retain
      |=> rsp.rb_len == cfg_regs_pkg::RB_LEN_RST)
      else $error("config not cleared on power-down");
   a_ro_ignore: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      req.wr && req.addr == cfg_regs_pkg::OFS_RSVD4 && !power_down
      |=> $stable(imp_sel) && $stable(config_retain))
      else $error("reserved write changed state");
   a_imp_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
      req.wr && req.addr == cfg_regs_pkg::OFS_STOP_FB && !power_down
      |=> imp_sel[9:8] == $past(req.wdata[7:6]))
      else $error("feedback impedance not written");

   // reset values, checked one edge after the synchronous reset is seen; the type byte read two edges after
   a_retain_reset: assert property (@(posedge mclk) // RULE5
      !resetn |=> config_retain)
      else $error("retention bit not set after reset");
   a_imp_reset: assert property (@(posedge mclk) // RULE7
      !resetn |=> imp_sel == {5{IMP_RST}})
      else $error("impedance codes wrong after reset");
   a_pairs_reset: assert property (@(posedge mclk) // RULE9
      !resetn |=> pair_true_out == 4'h0 && pair_comp_out == 4'h0
      && pair_hiz == 4'h0)
      else $error("pair drive not idle after reset");
   a_type_reset: assert property (@(posedge mclk) // RULE2
      !resetn ##1 resetn && req.addr == cfg_regs_pkg::OFS_DEV_TYPE
      |=> rsp.rdata == {TYPE_RST, PART_ID_RST})
      else $error("type byte wrong after reset");

   // read path: each byte shows the state of the cycle it was addressed in
   a_len_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE3
      req.addr == cfg_regs_pkg::OFS_RB_LEN
      |=> rsp.rdata == {3'h0, $past(rsp.rb_len)})
      else $error("read-back length byte wrong");
   a_len_rsvd: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      req.addr == cfg_regs_pkg::OFS_RB_LEN |=> rsp.rdata[7:5] == 3'h0)
      else $error("length byte reserved bits set");
   a_rsvd4_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
      req.addr == cfg_regs_pkg::OFS_RSVD4 |=> rsp.rdata == 8'h00)
      else $error("reserved byte 4 not zero");
   a_rsvd9_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
      req.addr == cfg_regs_pkg::OFS_RSVD9 |=> rsp.rdata == 8'h00)
      else $error("reserved byte 9 not zero");
   a_unmap_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE8
      req.addr > cfg_regs_pkg::OFS_IMP_HI |=> rsp.rdata == 8'h00)
      else $error("unmapped byte not zero");
   a_retain_read: assert property (@(posedge mclk) disable iff (!resetn) // RULE11
      req.addr == cfg_regs_pkg::OFS_RETAIN
      |=> rsp.rdata == {1'b0, $past(config_retain), 6'h00})
      else $error("retention byte readback wrong");

   // write path: each writable field lands one edge after the strobe
   a_retain_write: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      req.wr && req.addr == cfg_regs_pkg::OFS_RETAIN
      |=> config_retain == $past(req.wdata[6]))
      else $error("retention bit not written");
   a_imp_lo: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
      req.wr && req.addr == cfg_regs_pkg::OFS_IMP_LO && !power_down
      |=> imp_sel[3:0] == {$past(req.wdata[7:6]), $past(req.wdata[3:2])})
      else $error("low pair impedance not written");
   a_imp_hi: assert property (@(posedge mclk) disable iff (!resetn) // RULE7
      req.wr && req.addr == cfg_regs_pkg::OFS_IMP_HI && !power_down
      |=> imp_sel[7:4] == {$past(req.wdata[5:4]), $past(req.wdata[1:0])})
      else $error("high pair impedance not written");
   a_len_hold: assert property (@(posedge mclk) disable iff (!resetn) // RULE4
      !req.wr && !power_down |=> $stable(rsp.rb_len))
      else $error("read-back length moved by itself");

   // power-down: retention keeps the bytes, no retention reloads them
   a_retain_keep: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      power_down && config_retain && !req.wr
      |=> $stable(imp_sel) && $stable(rsp.rb_len))
      else $error("config lost with retention set");
   a_pd_imp: assert property (@(posedge mclk) disable iff (!resetn) // RULE5
      power_down && !config_retain |=> imp_sel == {5{IMP_RST}})
      else $error("impedance not cleared on power-down");

   // pair drive: enabled pairs run, disabled pairs show the stop code
   a_pair_on: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      pair_enable[0] |=> pair_true_out[0] && !pair_hiz[0])
      else $error("enabled pair not running");
   a_stop_ll: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      !pair_enable[2] && st_r.stop == cfg_regs_pkg::STOP_LOW_LOW
      |=> !pair_true_out[2] && !pair_comp_out[2] && !pair_hiz[2])
      else $error("pair not low/low");
   a_stop_hl: assert property (@(posedge mclk) disable iff (!resetn) // RULE9
      !pair_enable[2] && st_r.stop == cfg_regs_pkg::STOP_HIGH_LOW
      |=> pair_true_out[2] && !pair_comp_out[2])
      else $error("pair not high/low");
   a_stop_lh: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      !pair_enable[3] && st_r.stop == cfg_regs_pkg::STOP_LOW_HIGH
      |=> !pair_true_out[3] && pair_comp_out[3])
      else $error("pair not low/high");
   a_stop_hiz3: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      !pair_enable[3] && st_r.stop == cfg_regs_pkg::STOP_HIZ
      |=> pair_hiz[3] && !pair_comp_out[3])
      else $error("pair 3 not high impedance");
   a_hiz_quiet: assert property (@(posedge mclk) disable iff (!resetn) // RULE6
      pair_hiz[1] |-> !pair_true_out[1] && !pair_comp_out[1])
      else $error("high impedance pair still driven");
endmodule // clock_buffer_config_regs

// >>> sim/host_model.sv
// Purpose: behavioural bus engine driving byte accesses into the cfg bytes
// Assumes: one access per cycle, inputs changed at the falling edge
// Notes: read expectations are queued here and popped by the bench monitor
`timescale 1ns/1ns
module host_model (
   input wire logic mclk,
   output cfg_regs_pkg::reg_req_t req,
   output logic rd_valid
);
   logic [7:0] expq[$];

   initial begin
      req = '0;
      rd_valid = 1'b0;
   end

   // one byte per cycle, held until the next falling edge
   // callers never pass impedance code 11 in write data
   task automatic acc(input logic wr, input logic [7:0] a, d, e);
      @(negedge mclk);
      req.wr = wr;
      req.addr = a;
      req.wdata = d;
      rd_valid = !wr;
      if (!wr) begin
         expq.push_back(e);
      end
   endtask

   // released bus shows inverted values so stale data never looks valid
   task automatic idle();
      @(negedge mclk);
      req.wr = 1'b0;
      rd_valid = 1'b0;
      req.addr = ~req.addr;
      req.wdata = ~req.wdata;
   endtask
endmodule // host_model

// >>> sim/tb_top.sv
// Purpose: self-checking bench for the clock buffer config bytes
// Assumes: host_model drives the byte port; bench drives enables and pd
// Notes: read data is checked by a monitor one cycle after the address
`timescale 1ns/1ns
module tb_top;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] pair_enable = 4'hF;
   logic power_down = 1'b0;
   logic rv_d = 1'b0;
   int miscompares = 0;
   int checked = 0;
   cfg_regs_pkg::reg_req_t req;
   cfg_regs_pkg::reg_rsp_t rsp;
   logic [3:0] p_t, p_c, p_h, en;
   logic [9:0] imp_sel;
   logic config_retain, rd_valid;
   logic [7:0] w;
   localparam logic [7:0] RST_EXP [10] = '{8'h00, 8'hA5, 8'h6C, 8'h08,
      8'h00, 8'h00, 8'h40, 8'h80, 8'h88, 8'h22};
   localparam logic [7:0] WR_VAL [10] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF,
      8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h77, 8'hD9};
   localparam logic [7:0] WR_EXP [10] = '{8'h00, 8'hA5, 8'hFF, 8'h1F,
      8'h00, 8'h00, 8'h40, 8'h43, 8'h44, 8'h11};

   always #4 mclk = ~mclk;

   host_model i_host_model (.mclk(mclk), .req(req), .rd_valid(rd_valid));

   // identity values are arbitrary
   clock_buffer_config_regs #(.REVISION_CODE(4'hA), .MAKER_CODE(4'h5),
      .PART_ID_RST(6'h2C)) i_clock_buffer_config_regs (.mclk(mclk),
      .resetn(resetn), .req(req), .pair_enable(pair_enable),
      .power_down(power_down), .rsp(rsp), .pair_true_out(p_t),
      .pair_comp_out(p_c), .pair_hiz(p_h), .imp_sel(imp_sel),
      .config_retain(config_retain));

   task automatic check(input logic [9:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results();
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // read data lands one edge after the address, so compare a cycle later
   always @(posedge mclk) rv_d <= rd_valid;
   always @(negedge mclk) begin
      if (rv_d === 1'b1) begin
         check(rsp.rdata, i_host_model.expq.pop_front());
      end
   end

   initial begin
      void'($urandom(44));
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      check(rsp.rb_len, 5'h08);
      check(config_retain, 1'b1);
      check(imp_sel, 10'h2AA);
      // reset values back to back, then an unmapped byte
      for (int i = 0; i < 10; i++) begin
         i_host_model.acc(1'b0, 8'(i + 4), 8'h00, RST_EXP[i]);
      end
      i_host_model.acc(1'b0, 8'h3C, 8'h00, 8'h00);
      for (int i = 0; i < 10; i++) begin
         i_host_model.acc(1'b1, 8'(i + 4), WR_VAL[i], 8'h00);
      end
      i_host_model.idle();
      check(rsp.rb_len, 5'h1F);
      check(imp_sel, 10'h155);
      for (int i = 0; i < 10; i++) begin
         i_host_model.acc(1'b0, 8'(i + 4), 8'h00, WR_EXP[i]);
      end
      // write then read in the next cycle catches a lagging register
      w = 8'($urandom);
      i_host_model.acc(1'b1, 8'h06, w, 8'h00);
      i_host_model.acc(1'b0, 8'h06, 8'h00, w);
      i_host_model.acc(1'b1, 8'h07, 8'hE5, 8'h00);
      i_host_model.idle();
      check(rsp.rb_len, 5'h05);
      // every stop code against a random enable mix
      for (int s = 0; s < 4; s++) begin
         en = 4'($urandom);
         pair_enable = en;
         i_host_model.acc(1'b1, 8'h0B, {6'h10, 2'(s)}, 8'h00);
         i_host_model.idle();
         @(negedge mclk);
         check(p_t, en | (~en & {4{s == 2}}));
         check(p_c, ~en & {4{s == 3}});
         check(p_h, ~en & {4{s == 1}});
      end
      // power-down keeps config with retain set, clears it otherwise
      power_down = 1'b1;
      repeat (2) @(negedge mclk);
      check(imp_sel, 10'h155);
      power_down = 1'b0;
      i_host_model.acc(1'b1, 8'h0A, 8'h00, 8'h00);
      i_host_model.idle();
      check(config_retain, 1'b0);
      power_down = 1'b1;
      @(negedge mclk);
      check(imp_sel, 10'h2AA);
      check(rsp.rb_len, 5'h08);
      power_down = 1'b0;
      repeat (2) @(negedge mclk);
      results();
   end

   // run needs under a hundred cycles; this leaves ample margin
   initial begin
      #20000;
      miscompares++;
      results();
   end
endmodule // tb_top
